// file: hmp_pkg.sv
package hmp_pkg;
  // ---------------------------------------------------------------
  // Port register selects
  // ---------------------------------------------------------------
  localparam logic [1:0]  SEL_DATA    = 2'h0;
  localparam logic [1:0]  SEL_MAILBOX = 2'h1;
  localparam logic [1:0]  SEL_ADDR    = 2'h2;
  localparam logic [1:0]  SEL_STATUS  = 2'h3;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          WORD_W      = 16;
  localparam int          MEM_AW      = 16;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [15:0] PTR_STEP    = 16'h0001;
  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int          ST_OUT_FULL = 0;
  localparam int          ST_IN_FULL  = 1;
  localparam int          ST_MEM_BUSY = 2;
  // ---------------------------------------------------------------
  // Boot time the host must wait out after reset
  // ---------------------------------------------------------------
  localparam int          BOOT_TIME_MS = 3;
  typedef enum logic [1:0] {
    HMP_IDLE  = 2'b00,
    HMP_WRITE = 2'b01,
    HMP_READ  = 2'b10
  } hmp_state_t;
endpackage : hmp_pkg

// file: hmp_host_port.sv
`timescale 1ns/10ps
// Function
// - The two select lines pick data, mailbox, address pointer or status.
// - Every port access moves one whole 16-bit word on the data lines.
// - Each data register access advances the address pointer by one.
// - Data register writes go straight to internal memory at the pointer; reads return a word prefetched from there.
// - The mailbox carries messages both from host to core and core to host.
// - The interrupt output is high while an outgoing message waits.
// - Strobes are active low and an access completes on the rising edge.
// - The status word is readable anytime with no side effects.
module hmp_host_port (
  input  wire logic        clk,                 // System clock
  input  wire logic        rst,                 // Async reset, active high
  input  wire logic        port_select_n,       // Host chip select
  input  wire logic        read_strobe_n,       // Host read strobe
  input  wire logic        write_strobe_n,      // Host write strobe
  input  wire logic        reg_sel_hi,          // Register select bit 1
  input  wire logic        reg_sel_lo,          // Register select bit 0
  input  wire logic [15:0] hostDataIn,          // Data lines in
  output logic      [15:0] hostDataOut,         // Data lines out
  output logic             hostDataOe,          // Data lines enable
  output logic             outgoing_mailbox_irq,// Outgoing message pending
  output logic      [15:0] memAddr,             // Memory address
  output logic      [15:0] memWrData,           // Memory write data
  output logic             memWrEn,             // Memory write pulse
  output logic             memRdEn,             // Memory read pulse
  input  wire logic [15:0] memRdData,           // Memory read data
  input  wire logic        memAck,              // Memory access done
  input  wire logic        cpuMboxWr,           // Core posts outgoing msg
  input  wire logic [15:0] cpuMboxWrData,       // Outgoing message
  input  wire logic        cpuMboxRd,           // Core takes incoming msg
  output logic      [15:0] cpuMboxRdData,       // Incoming message
  output logic             cpuMboxFull          // Incoming message waiting
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hmp_pkg::hmp_state_t state_r;
  hmp_pkg::hmp_state_t state_nxt;
  logic [15:0]         ptr_r;
  logic [15:0]         ptr_nxt;
  logic [15:0]         outBox_r;
  logic [15:0]         outBox_nxt;
  logic [15:0]         inBox_r;
  logic [15:0]         inBox_nxt;
  logic [15:0]         rdLatch_r;
  logic [15:0]         rdLatch_nxt;
  logic [15:0]         dOut_r;
  logic [15:0]         dOut_nxt;
  logic [15:0]         mAddr_r;
  logic [15:0]         mAddr_nxt;
  logic [15:0]         mWd_r;
  logic [15:0]         mWd_nxt;
  logic                outFull_r;
  logic                outFull_nxt;
  logic                inFull_r;
  logic                inFull_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic                mWe_r;
  logic                mWe_nxt;
  logic                mRe_r;
  logic                mRe_nxt;
  logic                rdPrev_r;
  logic                wrPrev_r;
  logic                irq_r;
  logic [1:0]          sel;
  logic                rdQual;
  logic                wrQual;
  logic                rdEnd;
  logic                wrEnd;

  function automatic logic [15:0] bump(input logic [15:0] p);
    bump = p + hmp_pkg::PTR_STEP;
  endfunction : bump

  // ---------------------------------------------------------------
  // Host strobe decode
  // ---------------------------------------------------------------
  assign sel    = {reg_sel_hi, reg_sel_lo};
  assign rdQual = !port_select_n && !read_strobe_n;
  assign wrQual = !port_select_n && !write_strobe_n;
  assign rdEnd  = rdPrev_r && !rdQual;
  assign wrEnd  = wrPrev_r && !wrQual;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    ptr_nxt     = ptr_r;
    outBox_nxt  = outBox_r;
    inBox_nxt   = inBox_r;
    outFull_nxt = outFull_r;
    inFull_nxt  = inFull_r;
    rdLatch_nxt = rdLatch_r;
    mAddr_nxt   = mAddr_r;
    mWd_nxt     = mWd_r;
    mWe_nxt     = 1'b0;
    mRe_nxt     = 1'b0;
    oe_nxt      = rdQual;
    // Core side of mailbox; a host mailbox write below beats cpuMboxRd, but cpuMboxWr beats a host mailbox read
    if (cpuMboxRd) inFull_nxt = 1'b0;
    if (cpuMboxWr) begin
      outBox_nxt  = cpuMboxWrData;
      outFull_nxt = 1'b1;
    end
    case (sel)
      hmp_pkg::SEL_DATA:    dOut_nxt = rdLatch_r;
      hmp_pkg::SEL_MAILBOX: dOut_nxt = outBox_r;
      hmp_pkg::SEL_ADDR:    dOut_nxt = ptr_r;
      hmp_pkg::SEL_STATUS:  dOut_nxt = {13'h0000,
                               state_r != hmp_pkg::HMP_IDLE,
                               inFull_r, outFull_r};
      default:              dOut_nxt = hmp_pkg::WORD_RST;
    endcase
    // Memory answers first, so a status or mailbox access never loses one
    case (state_r)
      hmp_pkg::HMP_WRITE: begin
        if (memAck) begin
          state_nxt = hmp_pkg::HMP_READ;
          mAddr_nxt = ptr_r;
          mRe_nxt   = 1'b1;
        end
      end
      hmp_pkg::HMP_READ: begin
        if (memAck) begin
          rdLatch_nxt = memRdData;
          state_nxt   = hmp_pkg::HMP_IDLE;
        end
      end
      default: state_nxt = hmp_pkg::HMP_IDLE;
    endcase
    if (wrEnd) begin
      case (sel)
        hmp_pkg::SEL_DATA: begin
          mAddr_nxt = ptr_r;
          mWd_nxt   = hostDataIn;
          mWe_nxt   = 1'b1;
          ptr_nxt   = bump(ptr_r);
          state_nxt = hmp_pkg::HMP_WRITE;
        end
        hmp_pkg::SEL_MAILBOX: begin
          inBox_nxt  = hostDataIn;
          inFull_nxt = 1'b1;
        end
        hmp_pkg::SEL_ADDR: begin
          ptr_nxt   = hostDataIn;
          mAddr_nxt = hostDataIn;
          mRe_nxt   = 1'b1;
          state_nxt = hmp_pkg::HMP_READ;
        end
        default: ;
      endcase
    end else if (rdEnd) begin
      case (sel)
        hmp_pkg::SEL_DATA: begin
          ptr_nxt   = bump(ptr_r);
          mAddr_nxt = bump(ptr_r);
          mRe_nxt   = 1'b1;
          state_nxt = hmp_pkg::HMP_READ;
        end
        hmp_pkg::SEL_MAILBOX: outFull_nxt = cpuMboxWr;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= hmp_pkg::HMP_IDLE;
      ptr_r     <= hmp_pkg::WORD_RST;
      outBox_r  <= hmp_pkg::WORD_RST;
      inBox_r   <= hmp_pkg::WORD_RST;
      rdLatch_r <= hmp_pkg::WORD_RST;
      dOut_r    <= hmp_pkg::WORD_RST;
      mAddr_r   <= hmp_pkg::WORD_RST;
      mWd_r     <= hmp_pkg::WORD_RST;
      outFull_r <= 1'b0;
      inFull_r  <= 1'b0;
      oe_r      <= 1'b0;
      mWe_r     <= 1'b0;
      mRe_r     <= 1'b0;
      rdPrev_r  <= 1'b0;
      wrPrev_r  <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ptr_r     <= ptr_nxt;
      outBox_r  <= outBox_nxt;
      inBox_r   <= inBox_nxt;
      rdLatch_r <= rdLatch_nxt;
      dOut_r    <= dOut_nxt;
      mAddr_r   <= mAddr_nxt;
      mWd_r     <= mWd_nxt;
      outFull_r <= outFull_nxt;
      inFull_r  <= inFull_nxt;
      oe_r      <= oe_nxt;
      mWe_r     <= mWe_nxt;
      mRe_r     <= mRe_nxt;
      rdPrev_r  <= rdQual;
      wrPrev_r  <= wrQual;
      irq_r     <= outFull_nxt;
    end
  end

  assign hostDataOut          = dOut_r;
  assign hostDataOe           = oe_r;
  assign outgoing_mailbox_irq = irq_r;
  assign memAddr              = mAddr_r;
  assign memWrData            = mWd_r;
  assign memWrEn              = mWe_r;
  assign memRdEn              = mRe_r;
  assign cpuMboxRdData        = inBox_r;
  assign cpuMboxFull          = inFull_r;
endmodule : hmp_host_port

// file: hmp_checker.sv
`timescale 1ns/10ps
module hmp_checker (
  input wire logic clk,                  // System clock
  input wire logic rst,                  // Async reset, active high
  input wire logic port_select_n,        // Host chip select
  input wire logic read_strobe_n,        // Host read strobe
  input wire logic write_strobe_n,       // Host write strobe
  input wire logic reg_sel_hi,           // Register select bit 1
  input wire logic reg_sel_lo,           // Register select bit 0
  input wire logic hostDataOe,           // Data lines enable
  input wire logic outgoing_mailbox_irq, // Outgoing message pending
  input wire logic memWrEn,              // Memory write pulse
  input wire logic memRdEn,              // Memory read pulse
  input wire logic cpuMboxWr,            // Core posts outgoing msg
  input wire logic cpuMboxFull           // Incoming message waiting
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrHeld;
    !port_select_n && !write_strobe_n;
  endsequence
  sequence wrDone(logic [1:0] s);
    !port_select_n && !write_strobe_n
      ##1 write_strobe_n && {reg_sel_hi, reg_sel_lo} == s;
  endsequence
  sequence rdDone(logic [1:0] s);
    !port_select_n && !read_strobe_n
      ##1 read_strobe_n && {reg_sel_hi, reg_sel_lo} == s;
  endsequence
  chk_oe_on_read: assert property (
    !port_select_n && !read_strobe_n |=> hostDataOe) else $error("no oe");
  chk_oe_cause: assert property (
    hostDataOe |-> !$past(port_select_n) && !$past(read_strobe_n))
    else $error("stray oe");
  chk_irq_post: assert property (
    cpuMboxWr |=> outgoing_mailbox_irq) else $error("irq missing");
  chk_irq_cause: assert property (
    $rose(outgoing_mailbox_irq) |-> $past(cpuMboxWr)) else $error("irq");
  chk_irq_clear: assert property (
    rdDone(2'h1) ##0 !cpuMboxWr |-> ##[1:2] !outgoing_mailbox_irq)
    else $error("irq kept");
  chk_inbox_fill: assert property (
    wrDone(2'h1) |-> ##[1:2] cpuMboxFull) else $error("inbox empty");
  chk_data_write: assert property (
    wrDone(2'h0) |-> ##[1:2] memWrEn) else $error("no mem write");
  chk_addr_fetch: assert property (
    wrDone(2'h2) |=> memRdEn) else $error("no prefetch");
  chk_read_fetch: assert property (
    rdDone(2'h0) |=> memRdEn) else $error("no fetch after read");
  chk_wr_on_rise: assert property (
    wrHeld ##1 wrHeld |-> !memWrEn) else $error("write before rise");
endmodule : hmp_checker
bind hmp_host_port hmp_checker u_chk (
  .clk                  (clk),
  .rst                  (rst),
  .port_select_n        (port_select_n),
  .read_strobe_n        (read_strobe_n),
  .write_strobe_n       (write_strobe_n),
  .reg_sel_hi           (reg_sel_hi),
  .reg_sel_lo           (reg_sel_lo),
  .hostDataOe           (hostDataOe),
  .outgoing_mailbox_irq (outgoing_mailbox_irq),
  .memWrEn              (memWrEn),
  .memRdEn              (memRdEn),
  .cpuMboxWr            (cpuMboxWr),
  .cpuMboxFull          (cpuMboxFull)
);

// file: hmp_mem_model.sv
`timescale 1ns/10ps
module hmp_mem_model (
  input wire logic        clk, rst, memWrEn, memRdEn, // Port side
  input wire logic [15:0] memAddr, memWrData,         // Access
  input wire logic [3:0]  lag,                        // Answer delay
  output logic            memAck,                     // Done pulse
  output logic     [15:0] memRdData                   // Read word
);
  logic [15:0] mem [0:255];
  logic [15:0] adr;
  logic [3:0]  cnt;
  logic        busy;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {memAck, busy, cnt, adr, memRdData} <= '0;
    end else begin
      memAck <= 1'b0;
      memRdData <= ~memRdData;
      if (memWrEn) mem[memAddr[7:0]] <= memWrData;
      if (memWrEn || memRdEn) begin
        {busy, cnt, adr} <= {1'b1, lag, memAddr};
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        memAck <= 1'b1;
        memRdData <= mem[adr[7:0]];
      end else if (busy) cnt <= cnt - 4'h1;
    end
  end
endmodule : hmp_mem_model

// file: tb.sv
`timescale 1ns/10ps
module tb;
  logic clk, rst, selN, rdN, wrN, cWr, cRd, oe, irq, wEn, rEn, ack, full;
  logic [1:0]  sel;
  logic [3:0]  lag;
  logic [15:0] din, dout, mA, mWd, mRd, cD, cQ, lf, v, a, q[$];
  int          mismatches, comparisons;
  // Boot wait in clock cycles at 10 MHz
  localparam int BootCycles = hmp_pkg::BOOT_TIME_MS * 10000;
  hmp_host_port u_dut (.clk(clk), .rst(rst), .port_select_n(selN),
    .read_strobe_n(rdN), .write_strobe_n(wrN), .reg_sel_hi(sel[1]),
    .reg_sel_lo(sel[0]), .hostDataIn(din), .hostDataOut(dout),
    .hostDataOe(oe), .outgoing_mailbox_irq(irq), .memAddr(mA),
    .memWrData(mWd), .memWrEn(wEn), .memRdEn(rEn), .memRdData(mRd),
    .memAck(ack), .cpuMboxWr(cWr), .cpuMboxWrData(cD), .cpuMboxRd(cRd),
    .cpuMboxRdData(cQ), .cpuMboxFull(full));
  hmp_mem_model u_mem (.clk(clk), .rst(rst), .memWrEn(wEn), .memRdEn(rEn),
    .memAddr(mA), .memWrData(mWd), .lag(lag), .memAck(ack),
    .memRdData(mRd));
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  task check(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task hw(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk) {selN, wrN, sel, din} <= {2'b00, s, d};
    repeat (2) @(posedge clk);
    wrN <= 1'b1;
    @(posedge clk) selN <= 1'b1;
    din <= ~d;
  endtask : hw
  task hr(input logic [1:0] s, output logic [15:0] d);
    @(posedge clk) {selN, rdN, sel} <= {2'b00, s};
    repeat (2) @(posedge clk);
    @(negedge clk) d = dout;
    check({15'h0, oe}, 16'h0001);
    @(posedge clk) rdN <= 1'b1;
    @(posedge clk) selN <= 1'b1;
  endtask : hr
  task idle;
    for (int i = 0; i < 40; i++) begin
      hr(2'h3, v);
      if (v[2] === 1'b0) break;
    end
    check({15'h0, v[2]}, 16'h0000);
  endtask : idle
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (BootCycles + 5000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    {selN, rdN, wrN, cWr, cRd, sel, din, cD, lag, lf} = {5'h1c, 38'h0, 16'h2e};
    {rst, mismatches, comparisons} = {1'b1, 64'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hr(2'h3, v);
    check(v, 16'h0000);
    repeat (BootCycles) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      lag <= 4'(3 * k);
      lf = step(lf);
      a = {9'h0, lf[6:0]};
      hw(2'h2, a);
      idle;
      for (int j = 0; j < 4; j++) begin
        lf = step(lf);
        q.push_back(lf);
        hw(2'h0, lf);
        idle;
      end
      hw(2'h2, a);
      idle;
      repeat (4) begin
        hr(2'h0, v);
        check(v, q.pop_front());
        idle;
      end
      hr(2'h2, v);
      check(v, a + 16'h0004);
    end
    lf = step(lf);
    hw(2'h1, lf);
    repeat (2) @(negedge clk);
    check(cQ, lf);
    hr(2'h3, v);
    check(v, 16'h0002);
    @(posedge clk) cRd <= 1'b1;
    @(posedge clk) cRd <= 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0, full}, 16'h0000);
    lf = step(lf);
    @(posedge clk) {cWr, cD} <= {1'b1, lf};
    @(posedge clk) {cWr, cD} <= {1'b0, ~lf};
    repeat (2) @(negedge clk);
    check({15'h0, irq}, 16'h0001);
    hr(2'h1, v);
    check(v, lf);
    repeat (2) @(negedge clk);
    check({15'h0, irq}, 16'h0000);
    @(posedge clk) {sel, rdN, wrN} <= 4'h4;
    repeat (4) @(posedge clk);
    {rdN, wrN} <= 2'b11;
    repeat (2) @(negedge clk);
    check({14'h0, oe, full}, 16'h0000);
    hw(2'h3, 16'hffff);
    hr(2'h3, v);
    check(v, 16'h0000);
    stop_test();
  end
endmodule : tb
